// *** hw/prot_pkg.sv ***
// Package of timing constants and widths for the inverter protection logic.
package prot_pkg;
	// ------------------------------------------------------------------
	// Clock and documented times
	// ------------------------------------------------------------------
	localparam int CLK_MHZ        = 50;
	localparam int FILT_TIME_NS   = 3000;
	localparam int BLANK_TIME_NS  = 370;
	localparam int DELAY_TIME_NS  = 150;
	localparam int HOLD_TIME_MS   = 10;
	// Least times round up to whole cycles.
	localparam int FILT_CYC  = (FILT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int DELAY_CYC = (DELAY_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC  = HOLD_TIME_MS * CLK_MHZ * 1000;
	localparam int CNT_W     = 20;
	localparam int PHASES    = 3;
endpackage

// *** hw/prot_if.sv ***
// Interface carrying one filtered comparator level between modules.
`timescale 1ns/1ns
interface filt_if;
	logic raw;
	logic filt;
	modport src (output raw, input filt);
	modport flt (input raw, output filt);
endinterface

// *** hw/level_filter.sv ***
// Glitch filter: output follows input only after it is stable long enough.
`timescale 1ns/1ns
module level_filter #(
	parameter int TICKS = prot_pkg::FILT_CYC
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	filt_if.flt       port_f
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       out_q;
	logic       out_d;

	// Count cycles the input differs from the output; flip at TICKS.
	always_comb begin
		cnt_d = 8'h00;
		out_d = out_q;
		if (port_f.raw != out_q) begin
			if (cnt_q >= 8'(TICKS - 1)) begin
				out_d = port_f.raw;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			out_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign port_f.filt = out_q;
endmodule

// *** hw/inverter_fault_protection.sv ***
// Protection logic gating the three-phase gate drive signals.
// Behaviour
// - Boot supply low forces high gate off.
// - After boot recovery, wait for command rising edge.
// - Boot lockout never asserts fault.
// - Boot lockout detection filtered about 3 us.
// - Logic supply low forces phase one gates off.
// - Logic supply recovery resumes phase one following.
// - Logic supply lockout holds fault asserted.
// - Logic supply detection filtered about 3 us.
// - Overcurrent needs sense high through blanking time.
// - After 0.15 us delay, low gates off, fault.
// - Overcurrent fault held fixed 10 ms.
// - Over 120 C: low gates off, fault.
// - Thermal release at 100 C or below.
// - Fault asserted keeps all low gates off.
`timescale 1ns/1ns
module inverter_fault_protection #(
	parameter int HOLD_TICKS = prot_pkg::HOLD_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [2:0] high_side_cmd,
	input  wire logic [2:0] low_side_cmd,
	input  wire logic [2:0] boot_supply_ok,
	input  wire logic       logic_supply_ok,
	input  wire logic       sense_over_trip,
	input  wire logic       temp_over_hot,
	input  wire logic       temp_below_cool,
	output logic      [2:0] high_gate_drive,
	output logic      [2:0] low_gate_drive,
	output logic            fault_out,
	output logic            fault_oe
);
	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	// Every pin passes two flops; only the second stage is read onward.
	localparam int SW = 11;
	logic [SW-1:0] s1_q;
	logic [SW-1:0] s2_q;
	logic [SW-1:0] pin_in;
	assign pin_in = {high_side_cmd, low_side_cmd, boot_supply_ok,
		logic_supply_ok, sense_over_trip};

	// Temperature comparators are kept apart for readability.
	logic [1:0] t1_q;
	logic [1:0] t2_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			t1_q <= 2'h0;
			t2_q <= 2'h0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			t1_q <= {temp_over_hot, temp_below_cool};
			t2_q <= t1_q;
		end
	end

	logic [2:0] hcmd;
	logic [2:0] lcmd;
	logic [2:0] boot_ok_s;
	logic       vcc_ok_s;
	logic       sense_s;
	assign hcmd      = s2_q[10:8];
	assign lcmd      = s2_q[7:5];
	assign boot_ok_s = s2_q[4:2];
	assign vcc_ok_s  = s2_q[1];
	assign sense_s   = s2_q[0];

	// ------------------------------------------------------------------
	// Supply filters
	// ------------------------------------------------------------------
	// The comparator hysteresis (10.0/10.5 V, 11.0/11.5 V) is analog; the
	// ok inputs already carry it, so only the time filter lives here.
	filt_if boot_f [prot_pkg::PHASES] ();
	filt_if vcc_f ();
	logic [2:0] boot_ok_f;

	genvar g;
	generate
		for (g = 0; g < prot_pkg::PHASES; g++) begin : g_boot
			assign boot_f[g].raw = boot_ok_s[g];
			assign boot_ok_f[g]  = boot_f[g].filt;
			level_filter #(.TICKS(prot_pkg::FILT_CYC)) u_filt (
				.mclk   (mclk),
				.rst_n  (rst_n),
				.port_f (boot_f[g])
			);
		end
	endgenerate

	assign vcc_f.raw = vcc_ok_s;
	level_filter #(.TICKS(prot_pkg::FILT_CYC)) u_vcc_filt (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.port_f (vcc_f)
	);
	logic vcc_lock;
	assign vcc_lock = !vcc_f.filt;

	// ------------------------------------------------------------------
	// High-side lockout with re-arm on command edge
	// ------------------------------------------------------------------
	logic [2:0] boot_lock_q;
	logic [2:0] boot_lock_d;
	logic [2:0] hcmd_prev_q;

	// Lockout clears only at a fresh rising command edge after recovery.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			boot_lock_d[i] = boot_lock_q[i];
			if (!boot_ok_f[i]) begin
				boot_lock_d[i] = 1'b1;
			end else if (hcmd[i] && !hcmd_prev_q[i]) begin
				boot_lock_d[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			boot_lock_q <= 3'h7;
			hcmd_prev_q <= 3'h0;
		end else begin
			boot_lock_q <= boot_lock_d;
			hcmd_prev_q <= hcmd;
		end
	end

	// ------------------------------------------------------------------
	// Overcurrent: blanking, delay, hold
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {OC_IDLE, OC_BLANK, OC_DELAY, OC_HOLD} oc_t;
	oc_t        oc_q;
	oc_t        oc_d;
	logic [prot_pkg::CNT_W-1:0] oc_cnt_q;
	logic [prot_pkg::CNT_W-1:0] oc_cnt_d;

	// Sensing resumes only after the hold, so repeated trips are spaced.
	always_comb begin
		oc_d     = oc_q;
		oc_cnt_d = oc_cnt_q + 1'b1;
		case (oc_q)
			OC_IDLE: begin
				oc_cnt_d = '0;
				if (sense_s) begin
					oc_d = OC_BLANK;
				end
			end
			OC_BLANK: begin
				if (!sense_s) begin
					oc_d     = OC_IDLE;
					oc_cnt_d = '0;
				end else if (oc_cnt_q >=
					prot_pkg::CNT_W'(prot_pkg::BLANK_CYC - 2)) begin
					oc_d     = OC_DELAY;
					oc_cnt_d = '0;
				end
			end
			OC_DELAY: begin
				if (oc_cnt_q >=
					prot_pkg::CNT_W'(prot_pkg::DELAY_CYC - 1)) begin
					oc_d     = OC_HOLD;
					oc_cnt_d = '0;
				end
			end
			OC_HOLD: begin
				if (oc_cnt_q >= prot_pkg::CNT_W'(HOLD_TICKS - 1)) begin
					oc_d     = OC_IDLE;
					oc_cnt_d = '0;
				end
			end
			default: begin
				oc_d     = OC_IDLE;
				oc_cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			oc_q     <= OC_IDLE;
			oc_cnt_q <= '0;
		end else begin
			oc_q     <= oc_d;
			oc_cnt_q <= oc_cnt_d;
		end
	end

	// ------------------------------------------------------------------
	// Thermal shutdown with hysteresis
	// ------------------------------------------------------------------
	logic tsd_q;
	logic tsd_d;
	always_comb begin
		tsd_d = tsd_q;
		if (t2_q[1]) begin
			tsd_d = 1'b1;
		end else if (t2_q[0]) begin
			tsd_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tsd_q <= 1'b0;
		end else begin
			tsd_q <= tsd_d;
		end
	end

	// ------------------------------------------------------------------
	// Output gating
	// ------------------------------------------------------------------
	logic       fault;
	logic [2:0] hi_d;
	logic [2:0] lo_d;
	logic       fault_oe_d;
	assign fault = vcc_lock || (oc_q == OC_HOLD) || tsd_q;

	// Boot lockout is absent from the fault term on purpose.
	always_comb begin
		hi_d = hcmd & ~boot_lock_q;
		lo_d = lcmd;
		if (vcc_lock) begin
			hi_d[0] = 1'b0;
			lo_d[0] = 1'b0;
		end
		if (fault) begin
			lo_d = 3'h0;
		end
		fault_oe_d = fault;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			high_gate_drive <= 3'h0;
			low_gate_drive  <= 3'h0;
			fault_oe        <= 1'b0;
		end else begin
			high_gate_drive <= hi_d;
			low_gate_drive  <= lo_d;
			fault_oe        <= fault_oe_d;
		end
	end

	// The pin is open drain: only ever pulled low.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_out <= 1'b0;
		end else begin
			fault_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	fault_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
		fault_oe |-> low_gate_drive == 3'h0)
		else $error("Low gate on while fault asserted.");
	boot_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(boot_lock_q[0]) |-> !high_gate_drive[0])
		else $error("High gate on during boot lockout.");
	boot_nofault_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(!vcc_lock && oc_q != OC_HOLD && !tsd_q) |=> !fault_oe)
		else $error("Fault asserted without a cause.");
	vcc_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
		vcc_lock |=> fault_oe && !high_gate_drive[0])
		else $error("Logic supply lockout not reflected.");
	blank_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(oc_q == OC_BLANK && !sense_s) |=> oc_q == OC_IDLE)
		else $error("Short sense pulse not rejected.");
	delay_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(oc_q == OC_DELAY && $past(oc_q) == OC_BLANK) |->
		$past(oc_q, 18) == OC_BLANK ##8 oc_q == OC_HOLD)
		else $error("Overcurrent timing wrong.");
	hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(oc_q == OC_HOLD && $past(oc_q) != OC_HOLD) |=>
		(oc_q == OC_HOLD) [*8])
		else $error("Overcurrent hold ended early.");
	tsd_a: assert property (@(posedge mclk) disable iff (!rst_n)
		t2_q[1] |=> ##1 fault_oe)
		else $error("Thermal shutdown not flagged.");
	tsd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(tsd_q && !t2_q[0]) |=> tsd_q)
		else $error("Thermal shutdown released early.");
endmodule

// *** dv/mcu_model.sv ***
// Behavioural model of the motor controller that drives the phase commands.
`timescale 1ns/1ns
module mcu_model #(
	parameter int REACT   = 20,
	parameter int RESTART = 100
) (
	input  wire logic       mclk,
	input  wire logic       fault_n,
	input  wire logic [2:0] want_high,
	input  wire logic [2:0] want_low,
	output logic      [2:0] high_side_cmd,
	output logic      [2:0] low_side_cmd
);
	int fault_cnt = 0;
	int wait_cnt  = 0;

	// ------------------------------------------------------------------
	// Command drive
	// ------------------------------------------------------------------
	// The reaction is slow on purpose, so the block must gate on its own
	// before the commands drop; restart is scaled down to keep runs short.
	always @(posedge mclk) begin
		if (fault_n !== 1'b1) begin
			fault_cnt <= fault_cnt + 1;
			wait_cnt  <= RESTART;
		end else begin
			fault_cnt <= 0;
			if (wait_cnt > 0) begin
				wait_cnt <= wait_cnt - 1;
			end
		end
		if ((fault_n !== 1'b1 && fault_cnt >= REACT) ||
		    (fault_n === 1'b1 && wait_cnt > 0)) begin
			high_side_cmd <= 3'h0;
			low_side_cmd  <= 3'h0;
		end else begin
			high_side_cmd <= want_high;
			low_side_cmd  <= want_low;
		end
	end
endmodule

// *** dv/tb.sv ***
// Self-checking testbench for the inverter protection block.
`timescale 1ns/1ns
module tb;
	localparam int HOLD    = 50;
	localparam int RESTART = 100;

	logic       mclk = 1'b0;
	logic       rst_n;
	logic [2:0] want_high;
	logic [2:0] want_low;
	logic [2:0] high_side_cmd;
	logic [2:0] low_side_cmd;
	logic [2:0] boot_supply_ok;
	logic       logic_supply_ok;
	logic       sense_over_trip;
	logic       temp_over_hot;
	logic       temp_below_cool;
	logic [2:0] high_gate_drive;
	logic [2:0] low_gate_drive;
	logic       fault_out;
	logic       fault_oe;
	wire        fault_n;
	int         err_count = 0;
	int         n_tests   = 0;

	// The fault pin is open drain with a pull-up on the board.
	assign fault_n = fault_oe ? fault_out : 1'b1;

	// Clock of 50 MHz.
	always #10 mclk = ~mclk;

	inverter_fault_protection #(.HOLD_TICKS(HOLD)) u_dut (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.high_side_cmd   (high_side_cmd),
		.low_side_cmd    (low_side_cmd),
		.boot_supply_ok  (boot_supply_ok),
		.logic_supply_ok (logic_supply_ok),
		.sense_over_trip (sense_over_trip),
		.temp_over_hot   (temp_over_hot),
		.temp_below_cool (temp_below_cool),
		.high_gate_drive (high_gate_drive),
		.low_gate_drive  (low_gate_drive),
		.fault_out       (fault_out),
		.fault_oe        (fault_oe)
	);

	mcu_model #(.RESTART(RESTART)) u_mcu (
		.mclk          (mclk),
		.fault_n       (fault_n),
		.want_high     (want_high),
		.want_low      (want_low),
		.high_side_cmd (high_side_cmd),
		.low_side_cmd  (low_side_cmd)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Checks are taken on the falling edge, where outputs have settled.
	task automatic chk(input string nm, input logic [2:0] e);
		logic [2:0] g;
		@(negedge mclk);
		g = (nm == "high") ? high_gate_drive :
		    (nm == "low") ? low_gate_drive : {2'h0, fault_n};
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
		@(posedge mclk);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wait_fault(input logic lvl, input int lim);
		int i;
		i = 0;
		while (fault_n !== lvl && i < lim) begin
			@(negedge mclk);
			i++;
		end
		n_tests++;
		if (fault_n !== lvl) begin
			err_count++;
			$display("wrong value fault_n expected %b seen %b", lvl, fault_n);
			final_report();
		end
		@(posedge mclk);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_boot();
		cyc(1);
		boot_supply_ok <= 3'h6;
		cyc(100);
		chk("high", 3'h5);
		boot_supply_ok <= 3'h7;
		cyc(200);
		boot_supply_ok <= 3'h6;
		cyc(200);
		chk("high", 3'h4);
		chk("fault", 3'h1);
		boot_supply_ok <= 3'h7;
		cyc(200);
		chk("high", 3'h4);
		want_high <= 3'h4;
		cyc(10);
		want_high <= 3'h5;
		cyc(10);
		chk("high", 3'h5);
	endtask

	task automatic t_logic();
		cyc(1);
		logic_supply_ok <= 1'b0;
		cyc(100);
		logic_supply_ok <= 1'b1;
		chk("fault", 3'h1);
		cyc(200);
		logic_supply_ok <= 1'b0;
		wait_fault(1'b0, 200);
		chk("high", 3'h4);
		chk("low", 3'h0);
		cyc(300);
		chk("fault", 3'h0);
		logic_supply_ok <= 1'b1;
		wait_fault(1'b1, 200);
		cyc(RESTART + 20);
		chk("low", 3'h2);
		chk("high", 3'h5);
	endtask

	task automatic t_ocp();
		int n;
		cyc(1);
		sense_over_trip <= 1'b1;
		cyc(10);
		sense_over_trip <= 1'b0;
		cyc(40);
		chk("fault", 3'h1);
		sense_over_trip <= 1'b1;
		wait_fault(1'b0, 60);
		chk("low", 3'h0);
		sense_over_trip <= 1'b0;
		n = 1;
		while (fault_n === 1'b0 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		n_tests++;
		if (n < HOLD || n > HOLD + 3) begin
			err_count++;
			$display("wrong value hold expected %0d seen %0d", HOLD, n);
		end
		cyc(RESTART + 20);
		chk("low", 3'h2);
	endtask

	task automatic t_temp();
		cyc(1);
		temp_below_cool <= 1'b0;
		temp_over_hot   <= 1'b1;
		wait_fault(1'b0, 20);
		chk("low", 3'h0);
		temp_over_hot <= 1'b0;
		cyc(30);
		chk("fault", 3'h0);
		temp_below_cool <= 1'b1;
		wait_fault(1'b1, 20);
		cyc(RESTART + 20);
		chk("low", 3'h2);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rst_n           = 1'b0;
		want_high       = 3'h0;
		want_low        = 3'h0;
		boot_supply_ok  = 3'h7;
		logic_supply_ok = 1'b1;
		sense_over_trip = 1'b0;
		temp_over_hot   = 1'b0;
		temp_below_cool = 1'b1;
		cyc(5);
		rst_n     <= 1'b1;
		cyc(2);
		want_high <= 3'h5;
		want_low  <= 3'h2;
		cyc(10);
		chk("high", 3'h5);
		chk("low", 3'h2);
		t_boot();
		t_logic();
		t_ocp();
		t_temp();
		final_report();
	end
endmodule
